//--- cbc_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module cbc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    cbc_stream_if.snk inS,
    cbc_stream_if.src outS,
    output logic isEmpty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic [AW:0] wrPtr; // extra bit tells full from empty
    logic [AW:0] rdPtr;
    logic full;
    wire pushOk = inS.valid && inS.ready;
    wire popOk = outS.valid && outS.ready;

    // pointer compare gives honest flags
    assign full = (wrPtr[AW] != rdPtr[AW]) &&
        (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    assign isEmpty = (wrPtr == rdPtr);
    assign inS.ready = !full;
    assign outS.valid = !isEmpty;
    assign outS.data = mem[rdPtr[AW-1:0]];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (pushOk) begin
            mem[wrPtr[AW-1:0]] <= inS.data;
        end
    end

    // pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (pushOk) wrPtr <= wrPtr + 1'b1;
            if (popOk) rdPtr <= rdPtr + 1'b1;
        end
    end

    // a word written into an empty buffer shows at the output next clock
    a_fifo_first_word: assert property (@(posedge clk) disable iff (rst)
        (pushOk && isEmpty) |=> (outS.data == $past(inS.data)))
        else $error("fifo lost the first word");
endmodule

//--- cbc_local_bus.sv
// processor-side local bus cycle sequencer with read data fifo
`timescale 1ns/1ps
`include "cbc_map.svh"

module cbc_local_bus (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [31:0] reqAddr,
    input wire cbc_pkg::cbc_size_t reqSize,
    input wire logic reqWrite,
    input wire cbc_pkg::cbc_cyc_t reqType,
    input wire logic reqCacheable,
    input wire logic [63:0] reqWdata,
    output logic reqDone,
    output logic rdValid,
    input wire logic rdReady,
    output logic [31:0] rdData,
    output logic [3:0] rdLanes,
    output logic cycle_start_strobe_n,
    output logic [31:2] busAddr,
    output logic [3:0] lane_enables_n,
    output logic cycleWrite,
    output cbc_pkg::cbc_cyc_t cycleType,
    output logic final_transfer_flag_n,
    output logic parity_error_flag_n,
    input wire logic nonburst_ready_n,
    input wire logic burst_ready_n,
    input wire logic narrow8_width_n,
    input wire logic narrow16_width_n,
    input wire logic cacheable_grant_n,
    input wire logic [31:0] dataIn,
    input wire logic [3:0] parityIn,
    output logic [31:0] dataOut,
    output logic [3:0] parityOut,
    output logic dataOe
);
    // bytes movable this data cycle from offset, width and remainder
    function automatic logic [2:0] chunk(input logic [1:0] off,
        input logic n8, input logic n16, input logic [4:0] r);
        logic [2:0] raw;
        raw = `CBC_WORD_BYTES - {1'b0, off};
        if (n8) raw = 3'h1;
        else if (n16) raw = off[0] ? 3'h1 : 3'h2;
        if ({2'h0, raw} > r) chunk = r[2:0];
        else chunk = raw;
    endfunction

    cbc_pkg::cbc_state_t state; // sequencer state
    cbc_pkg::cbc_state_t next_state;
    logic [31:0] cycAddr; // byte address of the pending data cycle
    logic [31:0] startAddr; // first byte of the request
    logic [4:0] rem; // bytes still to move
    logic [63:0] wdata; // write bytes from the word at startAddr
    logic cacheReq; // request may become a line fill
    logic firstData; // first data cycle still pending
    logic lineFill; // line fill granted
    logic narrow8Q; // width and grant seen in the previous clock
    logic narrow16Q;
    logic grantQ;
    logic fifoEmpty;

    cbc_stream_if #(.WIDTH(`CBC_FIFO_WIDTH)) pushS ();
    cbc_stream_if #(.WIDTH(`CBC_FIFO_WIDTH)) popS ();

    // ready pins, active high inside
    wire rdyLow = !nonburst_ready_n;
    wire brdyLow = !burst_ready_n;
    wire anyReady = rdyLow || brdyLow;
    // ready is only looked at in the data phase, never in the strobe clock
    wire dataEnd = (state == cbc_pkg::ST_DATA) && anyReady;
    wire accept = (state == cbc_pkg::ST_IDLE) && reqValid && reqReady;
    wire special = (cycleType == cbc_pkg::CYC_HALT) ||
        (cycleType == cbc_pkg::CYC_INTA);

    // bytes moved at this ready, width taken from the clock before
    wire [2:0] doneCnt = chunk(cycAddr[1:0], narrow8Q, narrow16Q, rem);
    // a cacheable memory read granted in its first data cycle fills a line
    wire lineNow = dataEnd && firstData && !cycleWrite && cacheReq &&
        (cycleType == cbc_pkg::CYC_MEM) && grantQ && !lineFill;
    wire lineMode = lineFill || lineNow;
    wire [4:0] remAfter = lineNow ? (`CBC_LINE_BYTES - {2'h0, doneCnt}) :
        (rem - {2'h0, doneCnt});
    // low-order bytes first: address climbs by what was moved, wrapping inside its 16-byte block in a line fill
    wire [3:0] offAfter = cycAddr[3:0] + {1'b0, doneCnt};
    wire [31:0] linearAfter = cycAddr + {29'h0, doneCnt};
    wire [31:0] addrAfter = lineMode ? {cycAddr[31:4], offAfter} :
        linearAfter;
    wire moreAfter = dataEnd && (remAfter != 5'h0);
    wire narrowQ = narrow8Q || narrow16Q;
    // next item without a strobe: burst ready alone, burst was offered,
    // same block, and writes only on a narrow bus
    wire burstGo = moreAfter && brdyLow && !rdyLow && !special &&
        final_transfer_flag_n &&
        (addrAfter[31:4] == cycAddr[31:4]) &&
        (!cycleWrite || narrowQ);

    // values for the data cycle presented next
    wire load = accept || moreAfter;
    wire [31:0] presAddr = accept ? reqAddr : addrAfter;
    wire [4:0] presRem = accept ? (5'h01 << reqSize) : remAfter;
    wire [63:0] presWdata = accept ? reqWdata : wdata;
    wire presHigh = accept ? 1'b0 : (addrAfter[2] ^ startAddr[2]);
    wire [31:0] presData = presHigh ? presWdata[63:32] : presWdata[31:0];
    wire [2:0] presSpan = chunk(presAddr[1:0], 1'b0, 1'b0, presRem);
    wire [2:0] presEnd = {1'b0, presAddr[1:0]} + presSpan;
    wire [2:0] doneEnd = {1'b0, cycAddr[1:0]} + doneCnt;
    wire nextWrite = accept ? reqWrite : cycleWrite;

    // last-flag inputs for the data cycle shown in the coming clock
    wire [1:0] blOff = load ? presAddr[1:0] : cycAddr[1:0];
    wire [4:0] blRem = load ? presRem : rem;
    wire blFirst = accept || (firstData && !dataEnd);
    wire blCache = accept ?
        (reqCacheable && !reqWrite && (reqType == cbc_pkg::CYC_MEM)) :
        (cacheReq && !cycleWrite && (cycleType == cbc_pkg::CYC_MEM));
    wire blFillPend = blFirst && blCache && !cacheable_grant_n;
    wire [2:0] blCnt = chunk(blOff, !narrow8_width_n, !narrow16_width_n,
        blRem);
    wire blWordEnd = ({1'b0, blOff} + blCnt) == `CBC_WORD_BYTES;
    // writes end each bus word so no burst passes 32 bits
    wire blLast = (({2'h0, blCnt} == blRem) && !blFillPend) ||
        (nextWrite && blWordEnd);
    wire next_final_transfer_flag_n_n = !blLast;

    // per-lane decode: presented lanes, lanes moved, parity per lane
    logic [3:0] lanesP;
    logic [3:0] laneDone;
    logic [3:0] laneBad;
    logic [3:0] parP;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            localparam logic [2:0] LANE = 3'(gi);
            assign lanesP[gi] = (LANE >= {1'b0, presAddr[1:0]}) &&
                (LANE < presEnd);
            assign laneDone[gi] = (LANE >= {1'b0, cycAddr[1:0]}) &&
                (LANE < doneEnd);
            // even parity: nine bits carry an even count of ones
            assign laneBad[gi] = ^{dataIn[8*gi +: 8], parityIn[gi]};
            assign parP[gi] = ^presData[8*gi +: 8];
        end
    endgenerate

    // read words into the fifo at each read data cycle end
    assign pushS.valid = dataEnd && !cycleWrite;
    assign pushS.data = {laneDone, dataIn};
    assign popS.ready = rdReady;
    assign rdValid = popS.valid;
    assign rdData = popS.data[31:0];
    assign rdLanes = popS.data[35:32];

    cbc_fifo #(
        .WIDTH(`CBC_FIFO_WIDTH),
        .DEPTH(`CBC_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inS(pushS),
        .outS(popS),
        .isEmpty(fifoEmpty)
    );

    // sequencing: strobe clock, then data phase until the last ready
    always_comb begin
        next_state = state;
        case (state)
            cbc_pkg::ST_IDLE: begin
                if (accept) next_state = cbc_pkg::ST_ADDR;
            end
            cbc_pkg::ST_ADDR: begin
                next_state = cbc_pkg::ST_DATA;
            end
            cbc_pkg::ST_DATA: begin
                if (dataEnd) begin
                    if (!moreAfter) next_state = cbc_pkg::ST_IDLE;
                    else if (burstGo) next_state = cbc_pkg::ST_DATA;
                    else next_state = cbc_pkg::ST_ADDR;
                end
            end
            default: next_state = cbc_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) state <= cbc_pkg::ST_IDLE;
        else state <= next_state;
    end

    // request capture, held for the whole transfer
    always_ff @(posedge clk) begin
        if (rst) begin
            cycleWrite <= 1'b0;
            cycleType <= cbc_pkg::CYC_MEM;
            cacheReq <= 1'b0;
            wdata <= 64'h0;
            startAddr <= 32'h0;
        end else if (accept) begin
            cycleWrite <= reqWrite;
            cycleType <= reqType;
            cacheReq <= reqCacheable;
            wdata <= reqWdata;
            startAddr <= reqAddr;
        end
    end

    // address, lanes and write data change only at a load
    always_ff @(posedge clk) begin
        if (rst) begin
            cycAddr <= 32'h0;
            rem <= 5'h0;
            busAddr <= `CBC_ADDR_RST;
            lane_enables_n <= `CBC_LANES_RST;
            dataOut <= `CBC_DATA_RST;
            parityOut <= 4'h0;
        end else if (load) begin
            cycAddr <= presAddr;
            rem <= presRem;
            busAddr <= presAddr[31:2];
            lane_enables_n <= ~lanesP;
            dataOut <= presData;
            parityOut <= parP;
        end
    end

    // progress flags of the transfer
    always_ff @(posedge clk) begin
        if (rst) begin
            firstData <= 1'b0;
            lineFill <= 1'b0;
        end else begin
            if (accept) firstData <= 1'b1;
            else if (dataEnd) firstData <= 1'b0;
            if (accept) lineFill <= 1'b0;
            else if (lineNow) lineFill <= 1'b1;
        end
    end

    // width and grant are valid one clock before ready
    always_ff @(posedge clk) begin
        if (rst) begin
            narrow8Q <= 1'b0;
            narrow16Q <= 1'b0;
            grantQ <= 1'b0;
        end else begin
            narrow8Q <= !narrow8_width_n;
            narrow16Q <= !narrow16_width_n;
            grantQ <= !cacheable_grant_n;
        end
    end

    // bus strobes and last flag
    always_ff @(posedge clk) begin
        if (rst) begin
            cycle_start_strobe_n <= `CBC_STROBE_RST;
            final_transfer_flag_n <= `CBC_LAST_RST;
            dataOe <= 1'b0;
        end else begin
            cycle_start_strobe_n <= !(next_state == cbc_pkg::ST_ADDR);
            final_transfer_flag_n <= (next_state == cbc_pkg::ST_IDLE) ?
                `CBC_LAST_RST : next_final_transfer_flag_n_n;
            dataOe <= (next_state != cbc_pkg::ST_IDLE) && nextWrite;
        end
    end

    // parity flag stands for the one clock after a read ready
    always_ff @(posedge clk) begin
        if (rst) parity_error_flag_n <= `CBC_PERR_RST;
        else parity_error_flag_n <= !(dataEnd && !cycleWrite &&
            (|(laneDone & laneBad)));
    end

    // user handshake; a new request waits for the fifo to drain
    always_ff @(posedge clk) begin
        if (rst) begin
            reqReady <= 1'b0;
            reqDone <= 1'b0;
        end else begin
            reqReady <= (next_state == cbc_pkg::ST_IDLE) && fifoEmpty &&
                !pushS.valid && !accept;
            reqDone <= dataEnd && !moreAfter;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_strobe_one_clock: assert property (
        !cycle_start_strobe_n |=> cycle_start_strobe_n &&
        (state == cbc_pkg::ST_DATA))
        else $error("cycle strobe longer than one clock");
    a_start_after_accept: assert property (
        accept |=> !cycle_start_strobe_n && (busAddr == $past(reqAddr[31:2])))
        else $error("cycle did not start with its address");
    a_first_ready_ignored: assert property (
        (state == cbc_pkg::ST_ADDR) |=> (state == cbc_pkg::ST_DATA))
        else $error("ready taken in the strobe clock");
    a_last_flag_more: assert property (
        (dataEnd && final_transfer_flag_n && !special && !lineNow &&
        (doneCnt == 3'h4)) |-> moreAfter)
        else $error("inactive last flag ended the transfer");
    a_parity_after_read: assert property (
        !parity_error_flag_n |-> $past(dataEnd && !cycleWrite))
        else $error("parity flag without a read ready");
    a_write_burst_narrow: assert property (
        (dataEnd && cycleWrite && !narrowQ) |=>
        (!cycle_start_strobe_n || (state == cbc_pkg::ST_IDLE)))
        else $error("full width write burst");
    a_burst_block_fixed: assert property (
        burstGo |=> (busAddr[31:4] == $past(busAddr[31:4])) &&
        $stable(cycleType) && $stable(cycleWrite))
        else $error("burst left its block");
    a_both_ready_nonburst: assert property (
        (dataEnd && rdyLow && brdyLow && moreAfter) |=>
        (state == cbc_pkg::ST_ADDR) ##1 cycle_start_strobe_n)
        else $error("burst ready taken with non-burst ready");
    a_burst_no_strobe: assert property (
        burstGo |=> cycle_start_strobe_n)
        else $error("strobe inside a burst");
    a_wait_stable: assert property (
        ((state == cbc_pkg::ST_DATA) && !anyReady) |=>
        $stable(busAddr) && $stable(lane_enables_n) && $stable(dataOut))
        else $error("outputs moved during a wait");
    a_push_taken: assert property (
        pushS.valid |-> pushS.ready)
        else $error("read word lost at the fifo");
endmodule

//--- cbc_map.svh
// constants for the local bus cycle sequencer
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH

// bytes in one aligned burst block
`define CBC_LINE_BYTES 5'h10
// bytes in one physical bus word
`define CBC_WORD_BYTES 3'h4
// least clocks in one bus cycle, strobe clock plus ready clock
`define CBC_MIN_CYCLE_CLOCKS 2
// read fifo shape
`define CBC_FIFO_DEPTH 16
`define CBC_FIFO_WIDTH 36
// output levels after reset, all active-low pins inactive
`define CBC_STROBE_RST 1'b1
`define CBC_LAST_RST 1'b1
`define CBC_PERR_RST 1'b1
`define CBC_LANES_RST 4'hf
`define CBC_ADDR_RST 30'h0
`define CBC_DATA_RST 32'h0

`endif

//--- cbc_mem_model.sv
// partner model of the external memory side of the local bus
`timescale 1ns/1ps
module cbc_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic cycle_start_strobe_n,
    input wire logic [31:2] busAddr,
    input wire logic final_transfer_flag_n,
    input wire logic [3:0] waitCfg,
    input wire logic burstCfg,
    input wire logic bothCfg,
    input wire logic badParCfg,
    input wire logic n8Cfg,
    input wire logic n16Cfg,
    input wire logic grantCfg,
    output logic nonburst_ready_n,
    output logic burst_ready_n,
    output logic narrow8_width_n,
    output logic narrow16_width_n,
    output logic cacheable_grant_n,
    output logic [31:0] dataIn,
    output logic [3:0] parityIn
);
    logic active; // a bus cycle is open
    logic took; // a ready was sampled at this edge
    logic go; // answer in the coming clock
    logic [3:0] cnt; // wait clocks left
    logic [31:0] word; // answer made from the address, distinct per word

    // width and cache answers stand all the time, so they are always early
    assign narrow8_width_n = n8Cfg;
    assign narrow16_width_n = n16Cfg;
    assign cacheable_grant_n = grantCfg;
    assign word = {busAddr[17:2], ~busAddr[17:2]};

    initial begin
        active = 1'b0;
        cnt = 4'h0;
        nonburst_ready_n = 1'b1;
        burst_ready_n = 1'b1;
        dataIn = 32'h0;
        parityIn = 4'h0;
    end

    // cycle tracking on the edge, answers a small delay later
    always @(posedge clk) begin
        took = !nonburst_ready_n || !burst_ready_n;
        if (rst) begin
            active = 1'b0;
        end else if (!cycle_start_strobe_n) begin
            // last flag not looked at in the strobe clock
            active = 1'b1;
            cnt = waitCfg;
        end else if (active && took) begin
            // last flag read only with a ready
            if (!final_transfer_flag_n || !nonburst_ready_n) begin
                active = 1'b0; // non-burst: next item needs a strobe
            end else begin
                cnt = waitCfg; // burst: next item, maybe slow
            end
        end else if (active && cnt != 4'h0) begin
            cnt = cnt - 4'h1; // wait states by holding ready off
        end
        #1;
        go = active && cnt == 4'h0;
        // burst ready stays off while ready is off in simple mode
        burst_ready_n = !(go && burstCfg);
        // ready off with burst ready unless told to send both
        nonburst_ready_n = !(go && (!burstCfg || bothCfg));
        // released bus shows a changing pattern, not the last value
        dataIn = go ? word : ~dataIn;
        parityIn = go ? {^word[31:24], ^word[23:16], ^word[15:8],
            ^word[7:0] ^ badParCfg} : ~parityIn;
    end
endmodule

//--- cbc_pkg.sv
// types for the local bus cycle sequencer
package cbc_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } cbc_state_t;
    // cycle definition driven beside the address
    typedef enum logic [1:0] {
        CYC_MEM = 2'b00,
        CYC_IO = 2'b01,
        CYC_HALT = 2'b10,
        CYC_INTA = 2'b11
    } cbc_cyc_t;
    // request size code, bytes = 1 << code
    typedef enum logic [2:0] {
        SZ_1 = 3'b000,
        SZ_2 = 3'b001,
        SZ_4 = 3'b010,
        SZ_8 = 3'b011,
        SZ_16 = 3'b100
    } cbc_size_t;
endpackage

//--- cbc_stream_if.sv
// valid/ready stream between the sequencer and its fifo
`timescale 1ns/1ps
interface cbc_stream_if #(parameter int WIDTH = 36);
    logic valid; // word offered
    logic ready; // word taken when both high
    logic [WIDTH-1:0] data; // payload
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- tb_cpu_local_bus_cycle_control.sv
// self-checking bench for the local bus cycle sequencer
`timescale 1ns/1ps
module tb_cpu_local_bus_cycle_control;
    logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
    logic reqCacheable = 1'b0, rdReady = 1'b1;
    logic reqReady, reqDone, rdValid, cycle_start_strobe_n, cycleWrite;
    logic final_transfer_flag_n, parity_error_flag_n, dataOe;
    logic nonburst_ready_n, burst_ready_n, narrow8_width_n;
    logic narrow16_width_n, cacheable_grant_n;
    logic [31:0] reqAddr = 32'h0, rdData, dataIn, dataOut;
    logic [63:0] reqWdata = 64'h0;
    cbc_pkg::cbc_size_t reqSize = cbc_pkg::SZ_4;
    cbc_pkg::cbc_cyc_t reqType = cbc_pkg::CYC_MEM, cycleType;
    logic [3:0] rdLanes, lane_enables_n, parityIn, parityOut;
    logic [31:2] busAddr;
    // far-side behaviour knobs
    logic [3:0] waitCfg = 4'h0;
    logic burstCfg = 1'b0, bothCfg = 1'b0, badParCfg = 1'b0;
    logic n8Cfg = 1'b1, n16Cfg = 1'b1, grantCfg = 1'b1;
    int n_fail = 0, cmp_count = 0;
    int nStb = 0, nPerr = 0, nLast = 0, cyc = 0, tStb = 0, tDone = 0;
    int nOe = 0; // clocks with the write drivers on
    logic [35:0] rq[$]; // popped read words, lanes on top
    logic [39:0] wq[$]; // lanes, parity and write data at each ready of a write

    always #5 clk = ~clk;

    cbc_local_bus cbc_local_bus_inst (.clk, .rst, .reqValid, .reqReady,
        .reqAddr, .reqSize, .reqWrite, .reqType, .reqCacheable, .reqWdata,
        .reqDone, .rdValid, .rdReady, .rdData, .rdLanes,
        .cycle_start_strobe_n, .busAddr, .lane_enables_n, .cycleWrite,
        .cycleType, .final_transfer_flag_n, .parity_error_flag_n,
        .nonburst_ready_n, .burst_ready_n, .narrow8_width_n,
        .narrow16_width_n, .cacheable_grant_n, .dataIn, .parityIn,
        .dataOut, .parityOut, .dataOe);
    cbc_mem_model cbc_mem_model_inst (.clk, .rst, .cycle_start_strobe_n,
        .busAddr, .final_transfer_flag_n, .waitCfg, .burstCfg, .bothCfg,
        .badParCfg, .n8Cfg, .n16Cfg, .grantCfg, .nonburst_ready_n,
        .burst_ready_n, .narrow8_width_n, .narrow16_width_n,
        .cacheable_grant_n, .dataIn, .parityIn);

    // bus monitor: strobes, readies, last flags, parity, popped words
    always @(posedge clk) begin
        cyc++;
        if (cycle_start_strobe_n === 1'b0) begin
            if (nStb == 0) tStb = cyc;
            nStb++;
        end
        if (parity_error_flag_n === 1'b0) nPerr++;
        if (dataOe === 1'b1) nOe++;
        if (nonburst_ready_n === 1'b0 || burst_ready_n === 1'b0) begin
            if (final_transfer_flag_n === 1'b0) nLast++;
            if (cycleWrite === 1'b1)
                wq.push_back({lane_enables_n, parityOut, dataOut});
        end
        if (reqDone === 1'b1) tDone = cyc;
        if (rdValid === 1'b1 && rdReady) rq.push_back({rdLanes, rdData});
    end

    function automatic logic [31:0] wexp(input logic [31:0] a);
        return {a[17:2], ~a[17:2]};
    endfunction

    task automatic chk_int(input string nm, input int e, input int g);
        cmp_count++;
        if (e != g) begin
            n_fail++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [39:0] e,
        input logic [39:0] g);
        cmp_count++;
        if (e !== g) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // back to a quiet far side and cleared tallies
    task automatic clr();
        rq.delete();
        wq.delete();
        {nStb, nPerr, nLast} = {32'd0, 32'd0, 32'd0};
        nOe = 0;
        {waitCfg, burstCfg, bothCfg, badParCfg} = 7'h0;
        {n8Cfg, n16Cfg, grantCfg, rdReady} = 4'hf;
    endtask

    // one request: held until taken, then wait for the done pulse
    task automatic xfer(input logic [31:0] a, input cbc_pkg::cbc_size_t s,
        input logic w, input cbc_pkg::cbc_cyc_t t, input logic c,
        input logic [63:0] d);
        int k;
        reqAddr = a;
        reqSize = s;
        reqWrite = w;
        reqType = t;
        reqCacheable = c;
        reqWdata = d;
        reqValid = 1'b1;
        k = 0;
        while (reqReady !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        k = 0;
        while (reqDone !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_int("done", 1, int'(reqDone === 1'b1));
        repeat (4) @(posedge clk);
        #1;
    endtask

    // plain read with no and with three wait states
    task automatic s_single();
        for (int w = 0; w < 4; w += 3) begin
            clr();
            waitCfg = 4'(w);
            xfer(32'h10, cbc_pkg::SZ_4, 1'b0, cbc_pkg::CYC_MEM, 1'b0, 64'h0);
            chk_int("span", 2 + w, tDone - tStb);
            chk_int("strobes", 1, nStb);
            chk_int("last", 1, nLast);
            chk_int("perr", 0, nPerr);
            chk_int("oe", 0, nOe);
            chk_word("rd", {4'hf, wexp(32'h10)}, rq[0]);
        end
    endtask

    // eight-byte read, burst and non-burst and with both readies
    task automatic s_eight(input logic b, input logic both, input int ns);
        clr();
        {burstCfg, bothCfg} = {b, both};
        xfer(32'h100, cbc_pkg::SZ_8, 1'b0, cbc_pkg::CYC_MEM, 1'b0, 64'h0);
        chk_int("strobes", ns, nStb);
        chk_int("last", 1, nLast);
        chk_int("words", 2, rq.size());
        chk_word("rd0", {4'hf, wexp(32'h100)}, rq[0]);
        chk_word("rd1", {4'hf, wexp(32'h104)}, rq[1]);
        if (ns == 1) chk_int("span", 3, tDone - tStb);
    endtask

    // halt answered with burst ready ends as a single cycle
    task automatic s_halt();
        clr();
        burstCfg = 1'b1;
        xfer(32'h0, cbc_pkg::SZ_1, 1'b0, cbc_pkg::CYC_HALT, 1'b0, 64'h0);
        chk_int("strobes", 1, nStb);
        chk_int("span", 2, tDone - tStb);
        chk_int("type", int'(cbc_pkg::CYC_HALT), int'(cycleType));
    endtask

    // bad parity reported once, one clock after the ready
    task automatic s_parity();
        clr();
        badParCfg = 1'b1;
        xfer(32'h20, cbc_pkg::SZ_4, 1'b0, cbc_pkg::CYC_MEM, 1'b0, 64'h0);
        chk_int("perr", 1, nPerr);
    endtask

    // four bytes over a 16-bit bus, low half first
    task automatic s_narrow();
        clr();
        n16Cfg = 1'b0;
        xfer(32'h40, cbc_pkg::SZ_4, 1'b0, cbc_pkg::CYC_MEM, 1'b0, 64'h0);
        chk_int("strobes", 2, nStb);
        chk_word("lo", {4'h3, wexp(32'h40)}, rq[0]);
        chk_word("hi", {4'hc, wexp(32'h40)}, rq[1]);
    endtask

    // eight-byte write on a full bus never bursts past one word
    task automatic s_write();
        clr();
        burstCfg = 1'b1;
        xfer(32'h80, cbc_pkg::SZ_8, 1'b1, cbc_pkg::CYC_MEM, 1'b0,
            64'h11223344556677f8);
        chk_int("strobes", 2, nStb);
        chk_int("last", 2, nLast);
        chk_int("oe", 4, nOe);
        chk_word("w0", {8'h01, 32'h556677f8}, wq[0]);
        chk_word("w1", {8'h00, 32'h11223344}, wq[1]);
    endtask

    // byte-wide line fill fills the buffer while the reader stalls
    task automatic s_fill();
        clr();
        {n8Cfg, grantCfg, rdReady} = 3'h0;
        xfer(32'h200, cbc_pkg::SZ_4, 1'b0, cbc_pkg::CYC_MEM, 1'b1, 64'h0);
        chk_int("full", 1, int'(rdValid === 1'b1));
        chk_int("held", 1, int'(reqReady === 1'b0));
        chk_int("last", 1, nLast);
        rdReady = 1'b1;
        repeat (24) @(posedge clk);
        #1;
        chk_int("fill", 16, rq.size());
        chk_word("end", {4'h8, wexp(32'h20c)}, rq[15]);
        chk_int("empty", 1, int'(rdValid === 1'b0));
    endtask

    // reset in the middle of a waited read, then a clean read
    task automatic s_reset();
        logic [39:0] g;
        clr();
        waitCfg = 4'h8;
        reqAddr = 32'h300;
        reqCacheable = 1'b0;
        reqValid = 1'b1;
        while (reqReady !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        g = {29'h0, cycle_start_strobe_n, final_transfer_flag_n,
            parity_error_flag_n, lane_enables_n, reqReady, reqDone,
            rdValid, dataOe};
        chk_word("rst", 40'h7f0, g);
        chk_word("rstaddr", 40'h0, {10'h0, busAddr});
        rst = 1'b0;
        @(posedge clk);
        #1;
        chk_int("rdy", 1, int'(reqReady === 1'b1));
        waitCfg = 4'h0;
        xfer(32'h300, cbc_pkg::SZ_4, 1'b0, cbc_pkg::CYC_MEM, 1'b0, 64'h0);
        chk_word("rd", {4'hf, wexp(32'h300)}, rq[0]);
    endtask

    task automatic test_done();
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    // reset for three cycles, then every scenario in turn
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        s_single();
        s_eight(1'b1, 1'b0, 1);
        s_eight(1'b0, 1'b0, 2);
        s_eight(1'b1, 1'b1, 2);
        s_halt();
        s_parity();
        s_narrow();
        s_write();
        s_fill();
        s_reset();
        test_done();
    end
endmodule
